// ===== dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import wdt_pkg::*;
  logic clk, por_n, wd_rst_n, rstn, clk_en, slow_tick, debug_state, idle_state;
  logic [7:0] k;
  logic [31:0] rdata;
  reg_req_s req;
  fault_out_s fault;
  int n_errors, n_checks, seed, cyc, t0;
  assign rstn = por_n & wd_rst_n;
  windowed_watchdog_timer windowed_watchdog_timer_inst (.clk, .rstn, .clk_en, .slow_tick,
    .debug_state, .idle_state, .req, .rdata, .fault);
  wdt_partner wdt_partner_inst (.clk, .por_n, .fault, .slow_tick, .wd_rst_n);
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] cfgw(input logic [11:0] rv, wl, input logic [3:0] en);
    return {4'h0, wl, en, rv};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, w, !w};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(rdata, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    {debug_state, idle_state} <= 2'($random(seed));
    if (cyc == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    seed = 75;
    {por_n, clk_en} = 2'h0;
    req = '0;
    repeat (2) @(posedge clk);
    por_n <= 1;
    @(posedge clk);
    clk_en <= 1;
    rd(4'h4, 32'h3fff2fff);
    rd(4'h8, 32'h0);
    acc(1, 4'h0, 32'ha5000001);
    rd(4'h8, 32'h0);
    acc(1, 4'h4, cfgw(12'h3, 12'h1, 4'h1));
    acc(1, 4'h4, 32'hffffffff);
    rd(4'h4, cfgw(12'h3, 12'h1, 4'h1));
    repeat (8) begin
      k = 8'($random(seed));
      acc(1, 4'h0, {k == 8'ha5 ? 8'h5a : k, 24'($random(seed)) | 24'h1});
    end
    chk(fault.fault_irq, 0);
    acc(1, 4'h0, 32'ha5000001);
    t0 = cyc;
    chk(fault.fault_irq, 1);
    rd(4'h8, 32'h2);
    chk(fault.fault_irq, 0);
    while (!fault.fault_irq && cyc < t0 + 2000) @(negedge clk);
    chk((cyc - t0 + 8) / 16, 64);
    chk(fault.fault_to_reset_ctrl, 0);
    chk(fault.fault_proc_only, 0);
    rd(4'h8, 32'h1);
    $display("window and underflow done");
    @(posedge clk);
    por_n <= 0;
    @(posedge clk);
    por_n <= 1;
    acc(1, 4'h4, cfgw(12'h0, 12'hfff, 4'h6));
    while (!fault.fault_to_reset_ctrl && cyc < t0 + 4000) @(negedge clk);
    chk(fault.fault_proc_only, 1);
    repeat (6) @(posedge clk);
    rd(4'h4, 32'h3fff2fff);
    rd(4'h8, 32'h0);
    $display("fault reset done");
    acc(1, 4'h4, cfgw(12'h0, 12'hfff, 4'h9));
    repeat (600) @(posedge clk);
    #1;
    chk(fault.fault_irq, 0);
    rd(4'h8, 32'h0);
    $display("watchdog off done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== dv/wdt_partner.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_partner (
  input wire logic clk,
  input wire logic por_n,
  input wire wdt_pkg::fault_out_s fault,
  output logic slow_tick,
  output logic wd_rst_n
);
  import wdt_pkg::*;
  logic [1:0] hold_r;
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      slow_tick <= 1'b0;
      hold_r <= 2'h0;
    end else begin
      slow_tick <= !slow_tick;
      hold_r <= fault.fault_to_reset_ctrl ? 2'h3 : hold_r - 2'(hold_r != 2'h0);
    end
  end
  assign wd_rst_n = hold_r == 2'h0;
endmodule
`default_nettype wire

// ===== dv/wdt_sva.sv
`timescale 1ns/1ns
`default_nettype none
module wdt_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic slow_tick,
  input wire wdt_pkg::reg_req_s req,
  input wire logic [31:0] rdata,
  input wire wdt_pkg::fault_out_s fault
);
  import wdt_pkg::*;
  logic why, rd_ok;
  assign why = clk_en && (slow_tick || req.wr);
  assign rd_ok = clk_en && req.rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_srd; rd_ok && req.addr == 4'h8; endsequence
  property p_idle; $past(clk_en && !req.rd) |-> rdata == 32'h0; endproperty
  property p_shi; s_srd |=> rdata[31:2] == 30'h0; endproperty
  property p_clr; s_srd ##0 !slow_tick |=> fault[2:1] == 2'h0; endproperty
  property p_frz; !clk_en |=> $stable(fault); endproperty
  property p_iu; $rose(fault.fault_irq) |-> $past(why); endproperty
  property p_ru; $rose(fault.fault_to_reset_ctrl) |-> $past(why); endproperty
  property p_id; $fell(fault.fault_irq) |-> $past(rd_ok || (clk_en && req.wr)); endproperty
  property p_rdn; $fell(fault.fault_to_reset_ctrl) |-> $past(rd_ok || (clk_en && req.wr));
  endproperty
  a_idle: assert property (p_idle) else $error("rdata");
  a_shi: assert property (p_shi) else $error("status");
  a_clr: assert property (p_clr) else $error("clear");
  a_frz: assert property (p_frz) else $error("freeze");
  a_iu: assert property (p_iu) else $error("irq up");
  a_ru: assert property (p_ru) else $error("fault up");
  a_id: assert property (p_id) else $error("irq down");
  a_rdn: assert property (p_rdn) else $error("fault down");
endmodule
bind windowed_watchdog_timer wdt_sva wdt_sva_inst (.clk, .rstn, .clk_en, .slow_tick, .req,
  .rdata, .fault);
`default_nettype wire

// ===== hw/windowed_watchdog_timer.sv
// Operation
// RL1: 12-bit down counter loaded from reload value
// RL2: Counter ticks at slow clock divided by 128
// RL3: Reload resets to fff, watchdog runs
// RL4: Fault reset enable resets to one
// RL5: Config register written once until reset
// RL6: Config write reloads and restarts counter
// RL7: Keyed restart reloads counter and prescaler
// RL8: Control write needs key a5 in top byte
// RL9: Underflow sets flag, may request reset
// RL10: Early restart is window error, even disabled
// RL11: Window limit at or above reload disables check
// RL12: Flags raise interrupt when irq enabled
// RL13: Proc only select narrows reset scope
// RL14: Watchdog reset clears both flags
// RL15: Status read or reset clears flags, outputs
// RL16: Debug and idle halts stop counter
// RL17: Watchdog off stops the counter, not the window check
// RL18: Config layout and reset value fixed
// RL19: Status bits are sticky underflow and error
// RL20: Seven-bit prescaler wrap decrements counter
`include "wdt_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module windowed_watchdog_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic slow_tick,
  input wire logic debug_state,
  input wire logic idle_state,
  input wire wdt_pkg::reg_req_s req,
  output logic [31:0] rdata,
  output wdt_pkg::fault_out_s fault
);
  import wdt_pkg::*;

  wdt_state_s state_r;
  wdt_state_s state_nxt;
  logic key_ok;
  logic restart_req;
  logic cfg_write;
  logic status_read;
  logic halted;
  logic tick_dec;
  logic in_window;
  logic underflow_ev;
  logic error_ev;
  logic any_flag;

  // ============================================================
  // Request decode
  // ============================================================
  // Key check
  assign key_ok = (req.wdata[31:`KEY_LSB] == `RESTART_KEY);
  assign restart_req = req.wr && (req.addr == `RESTART_COMMAND_REG_OFF) && key_ok &&
                       req.wdata[`RESTART_BIT];
  // Write once
  assign cfg_write = req.wr && (req.addr == `WATCHDOG_CONFIG_REG_OFF) && !state_r.cfg_locked;
  assign status_read = req.rd && (req.addr == `FAULT_FLAGS_REG_OFF);

  // ============================================================
  // Counting
  // ============================================================
  // RL16: debug idle halt
  assign halted = (debug_state && state_r.cfg.halt_in_debug) ||
                  (idle_state && state_r.cfg.halt_in_idle);
  // RL20: prescaler wrap
  assign tick_dec = slow_tick && (state_r.prescale == `PRESCALE_LAST) &&
                    !state_r.cfg.watchdog_off && !halted;
  // RL11: window compare
  assign in_window = (state_r.count <= state_r.cfg.restart_window_limit) ||
                     (state_r.cfg.restart_window_limit >= state_r.cfg.reload_value);
  // RL10: early restart error
  assign error_ev = restart_req && !in_window;
  // RL9: underflow event
  assign underflow_ev = tick_dec && (state_r.count == 12'h000) && !restart_req && !cfg_write;

  // ============================================================
  // Next state
  // ============================================================
  always_comb begin
    state_nxt = state_r;
    // RL2: slow clock divide
    if (slow_tick) begin
      state_nxt.prescale = state_r.prescale + 7'h01;
    end
    if (tick_dec) begin
      // RL1: down counter
      state_nxt.count = state_r.count - 12'h001;
    end
    // RL9: reload after underflow
    if (underflow_ev) begin
      state_nxt.count = state_r.cfg.reload_value;
    end
    // RL7: restart reload
    if (restart_req) begin
      state_nxt.count = state_r.cfg.reload_value;
      state_nxt.prescale = '0;
    end
    // RL6: config reload
    if (cfg_write) begin
      state_nxt.cfg = wdt_cfg_s'(req.wdata[29:0]);
      state_nxt.cfg_locked = 1'b1;
      state_nxt.count = req.wdata[`CFG_RELOAD_LSB +: 12];
      state_nxt.prescale = '0;
    end
    // RL15: read clears
    if (status_read) begin
      state_nxt.underflow_flag = 1'b0;
      state_nxt.window_violation_flag = 1'b0;
    end
    // RL19: sticky set wins
    if (underflow_ev) begin
      state_nxt.underflow_flag = 1'b1;
    end
    if (error_ev) begin
      state_nxt.window_violation_flag = 1'b1;
    end
    // Read data
    state_nxt.rdata = 32'h0000_0000;
    if (req.rd) begin
      if (req.addr == `WATCHDOG_CONFIG_REG_OFF) begin
        state_nxt.rdata = {2'h0, state_r.cfg};
      end else if (status_read) begin
        state_nxt.rdata = {30'h0, state_r.window_violation_flag, state_r.underflow_flag};
      end
    end
    any_flag = state_nxt.underflow_flag || state_nxt.window_violation_flag;
    // RL12: interrupt gate
    state_nxt.fault.fault_irq = any_flag && state_nxt.cfg.fault_irq_enable;
    // RL9: fault request
    state_nxt.fault.fault_to_reset_ctrl = any_flag && state_nxt.cfg.fault_reset_enable;
    // RL13: reset scope
    state_nxt.fault.fault_proc_only = state_nxt.cfg.processor_only_reset_select;
  end

  // ============================================================
  // State register
  // ============================================================
  // RL3 RL4 RL14 RL18: reset values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r.cfg <= wdt_cfg_s'(30'(`CFG_RESET_VALUE));
      state_r.cfg_locked <= 1'b0;
      state_r.count <= 12'hfff;
      state_r.prescale <= '0;
      state_r.underflow_flag <= 1'b0;
      state_r.window_violation_flag <= 1'b0;
      state_r.rdata <= 32'h0000_0000;
      state_r.fault <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // RL17: watchdog off gates tick above
  assign rdata = state_r.rdata;
  assign fault = state_r.fault;

endmodule

`default_nettype wire

// ===== include/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Register offsets
`define RESTART_COMMAND_REG_OFF 4'h0
`define WATCHDOG_CONFIG_REG_OFF 4'h4
`define FAULT_FLAGS_REG_OFF 4'h8

// Config field positions
`define CFG_RELOAD_LSB 0
`define CFG_IRQ_EN_BIT 12
`define CFG_RST_EN_BIT 13
`define CFG_PROC_ONLY_BIT 14
`define CFG_OFF_BIT 15
`define CFG_WINDOW_LSB 16
`define CFG_HALT_DBG_BIT 28
`define CFG_HALT_IDLE_BIT 29

// Reset values
`define CFG_RESET_VALUE 32'h3fff2fff
`define FLAGS_RESET_VALUE 2'h0

// Restart key
`define KEY_LSB 24
`define RESTART_KEY 8'ha5
`define RESTART_BIT 0

// Timing: slow clock divided by 128
`define PRESCALE_WIDTH 7
`define PRESCALE_LAST 7'h7f

`endif

// ===== include/wdt_pkg.sv
package wdt_pkg;

  typedef struct packed {
    logic halt_in_idle;
    logic halt_in_debug;
    logic [11:0] restart_window_limit;
    logic watchdog_off;
    logic processor_only_reset_select;
    logic fault_reset_enable;
    logic fault_irq_enable;
    logic [11:0] reload_value;
  } wdt_cfg_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic fault_irq;
    logic fault_to_reset_ctrl;
    logic fault_proc_only;
  } fault_out_s;

  typedef struct packed {
    wdt_cfg_s cfg;
    logic cfg_locked;
    logic [11:0] count;
    logic [6:0] prescale;
    logic underflow_flag;
    logic window_violation_flag;
    logic [31:0] rdata;
    fault_out_s fault;
  } wdt_state_s;

endpackage
